// ==== rtl/sub_swap_core.sv ====
// Four-phase execution of subtract-with-borrow and nibble-swap
`default_nettype none
module sub_swap_core (
    input wire logic clock,
    input wire logic rstn,
    input wire logic start,
    input wire logic [1:0] opcode,
    input wire logic [7:0] file_addr,
    input wire logic dest_sel,
    input wire logic access_sel,
    input wire logic [3:0] bank_select_register,
    input wire logic extended_en,
    input wire logic [11:0] index_base,
    input wire logic carry_in,
    input wire logic [7:0] rdata,
    output logic [11:0] addr,
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] wdata,
    output logic [7:0] work_reg,
    output logic carry_out,
    output logic indexed_mode,
    output logic [3:0] phase,
    output logic busy,
    output logic done
);
    typedef enum logic [3:0] {
        DECODE = 4'h1,
        READ = 4'h2,
        PROCESS = 4'h4,
        WRITE = 4'h8
    } phase_t;
    ////////////////////////////////////////////////////////////////////////
    phase_t state_q, state_d;
    logic active_q, active_d;
    logic [1:0] op_q;
    logic dest_q;
    logic [11:0] addr_q;
    logic idx_q;
    logic [7:0] opnd_q, res_q, work_q;
    logic carry_q, carry_res_q;
    logic [7:0] alu_res;
    logic alu_carry;
    logic [11:0] eff_addr;
    logic use_indexed;
    logic valid_op;
    logic take;

    assign valid_op = (opcode == sub_swap_pkg::OP_SUB_BORROW) ||
        (opcode == sub_swap_pkg::OP_SWAP);
    assign take = (state_q == DECODE) && !active_q && start && valid_op;
    // Effective address: indexed, banked or access bank
    assign use_indexed = extended_en && !access_sel &&
        (file_addr <= sub_swap_pkg::INDEXED_MAX);
    assign eff_addr = use_indexed ?
        12'(index_base + {4'h0, file_addr})
        : access_sel ? {bank_select_register, file_addr}
        : (file_addr < sub_swap_pkg::ACCESS_SPLIT) ? {4'h0, file_addr}
        : {sub_swap_pkg::ACCESS_HIGH_BANK, file_addr};

    sub_swap_alu u_alu (
        .op(op_q),
        .file_val(opnd_q),
        .work_val(work_q),
        .carry_in(carry_q),
        .result(alu_res),
        .carry_out(alu_carry)
    );

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    always_comb
    begin
        state_d = state_q;
        active_d = active_q;
        case (state_q)
            DECODE:
            begin
                if (active_q)
                    state_d = READ;
                else if (start && valid_op)
                    active_d = 1'b1;
            end
            READ: state_d = PROCESS;
            PROCESS: state_d = WRITE;
            WRITE:
            begin
                state_d = DECODE;
                active_d = 1'b0;
            end
            default:
            begin
                state_d = DECODE;
                active_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= DECODE;
            active_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            active_q <= active_d;
        end
    end

    // Decode captures the instruction word fields
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            op_q <= sub_swap_pkg::OP_NONE;
            dest_q <= 1'b0;
            addr_q <= 12'h000;
            idx_q <= 1'b0;
            carry_q <= 1'b0;
        end
        else if (take)
        begin
            op_q <= opcode;
            dest_q <= dest_sel;
            addr_q <= eff_addr;
            idx_q <= use_indexed;
            carry_q <= carry_in;
        end
    end

    // Read, process and write phases
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            carry_res_q <= 1'b0;
            work_q <= sub_swap_pkg::W_RESET;
        end
        else
        begin
            if (state_q == READ)
                opnd_q <= rdata;
            if (state_q == PROCESS)
            begin
                res_q <= alu_res;
                carry_res_q <= alu_carry;
            end
            if (state_q == WRITE && !dest_q)
                work_q <= res_q;
        end
    end

    assign addr = addr_q;
    assign rd_en = (state_q == READ);
    assign wr_en = (state_q == WRITE) && dest_q;
    assign wdata = res_q;
    assign work_reg = work_q;
    assign carry_out = carry_res_q;
    assign indexed_mode = idx_q;
    assign phase = state_q;
    assign busy = active_q;
    assign done = (state_q == WRITE);

    ////////////////////////////////////////////////////////////////////////
    // Checks on sequencing, destinations and addressing
    a_four_phase: assert property (@(posedge clock)
        disable iff (!rstn)
        (state_q == DECODE && active_q) |=> rd_en ##1 !rd_en ##1 done)
        else $error("instruction did not take four phases");
    a_dest_file: assert property (@(posedge clock) disable iff (!rstn)
        done && dest_q |-> wr_en && wdata == res_q ##1
        work_reg == $past(work_reg))
        else $error("file destination not written");
    a_dest_work: assert property (@(posedge clock) disable iff (!rstn)
        done && !dest_q |=> work_reg == $past(res_q) && !$past(wr_en))
        else $error("working destination not written");
    a_sub_value: assert property (@(posedge clock) disable iff (!rstn)
        state_q == PROCESS && op_q == sub_swap_pkg::OP_SUB_BORROW |=>
        res_q == 8'($past(opnd_q) - $past(work_q) - {7'h00, !$past(carry_q)}))
        else $error("subtract with borrow result wrong");
    a_sub_carry: assert property (@(posedge clock) disable iff (!rstn)
        state_q == PROCESS && op_q == sub_swap_pkg::OP_SUB_BORROW |=>
        carry_out == ({1'b0, $past(opnd_q)} >=
        {1'b0, $past(work_q)} + {8'h00, !$past(carry_q)}))
        else $error("subtract with borrow carry wrong");
    a_swap_value: assert property (@(posedge clock)
        disable iff (!rstn)
        state_q == PROCESS && op_q == sub_swap_pkg::OP_SWAP |=>
        res_q == {$past(opnd_q[3:0]), $past(opnd_q[7:4])})
        else $error("nibble swap result wrong");
    a_bank_sel: assert property (@(posedge clock) disable iff (!rstn)
        state_q == DECODE && !active_q && start && valid_op && access_sel
        |=> addr == {$past(bank_select_register), $past(file_addr)})
        else $error("banked address wrong");
    a_indexed: assert property (@(posedge clock) disable iff (!rstn)
        state_q == DECODE && !active_q && start && valid_op |=>
        indexed_mode == ($past(extended_en) && !$past(access_sel) &&
        $past(file_addr) <= 8'h5f))
        else $error("indexed mode selection wrong");
    a_access_bank: assert property (@(posedge clock)
        disable iff (!rstn)
        take && !access_sel && !use_indexed |=>
        addr == {(($past(file_addr) < sub_swap_pkg::ACCESS_SPLIT) ? 4'h0
        : sub_swap_pkg::ACCESS_HIGH_BANK), $past(file_addr)})
        else $error("access bank address wrong");
    a_addr_held: assert property (@(posedge clock) disable iff (!rstn)
        active_q |=> addr == $past(addr))
        else $error("address changed during an instruction");
    a_work_held: assert property (@(posedge clock) disable iff (!rstn)
        !done |=> work_reg == $past(work_reg))
        else $error("working register changed outside a write");
    a_no_write: assert property (@(posedge clock) disable iff (!rstn)
        wr_en |-> state_q == WRITE && active_q)
        else $error("write outside the write phase");
endmodule
`default_nettype wire

// ==== rtl/sub_swap_pkg.sv ====
// Constants for the subtract-with-borrow and nibble-swap datapath
`default_nettype none
package sub_swap_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned ADDR_W = 12;
    // Highest file address that goes indexed in extended mode
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    // Access bank split: low addresses map to bank 0, high to bank f
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_SUB_BORROW = 2'h1;
    localparam logic [1:0] OP_SWAP = 2'h2;
    localparam logic [3:0] PH_DECODE = 4'h1;
    localparam logic [3:0] PH_READ = 4'h2;
    localparam logic [3:0] PH_PROCESS = 4'h4;
    localparam logic [3:0] PH_WRITE = 4'h8;
endpackage
`default_nettype wire

// ==== rtl/sub_swap_alu.sv ====
// Arithmetic unit: subtract with borrow and nibble swap
`default_nettype none
module sub_swap_alu (
    input wire logic [1:0] op,
    input wire logic [7:0] file_val,
    input wire logic [7:0] work_val,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out
);
    logic [8:0] diff;
    // f + ~W + C equals f - W - ~C in two's complement
    assign diff = {1'b0, file_val} + {1'b0, ~work_val} + {8'h00, carry_in};
    assign result = (op == sub_swap_pkg::OP_SWAP) ?
        {file_val[3:0], file_val[7:4]} : diff[7:0];
    assign carry_out = (op == sub_swap_pkg::OP_SUB_BORROW) ? diff[8]
        : carry_in;
endmodule
`default_nettype wire

// ==== dv/subtract_borrow_nibble_swap_test.sv ====
// Self-checking bench for the subtract-with-borrow and nibble-swap core
`default_nettype none
module subtract_borrow_nibble_swap_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic [1:0] opcode = 2'h0;
    logic [7:0] file_addr = 8'h00;
    logic [7:0] rdata = 8'h00;
    logic dest_sel = 1'b0;
    logic access_sel = 1'b0;
    logic extended_en = 1'b0;
    logic carry_in = 1'b0;
    logic [3:0] bank_select_register = 4'h0;
    logic [11:0] index_base = 12'h000;
    logic [11:0] addr;
    logic [7:0] wdata, work_reg;
    logic [3:0] phase;
    logic rd_en, wr_en, busy, done, carry_out, indexed_mode;
    int err_count = 0;
    int checked = 0;
    logic [7:0] w_model = 8'h00;
    logic [7:0] dirs [8] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'h00, 8'hff,
        8'h5f, 8'h80};
    always #5 clock = ~clock;
    sub_swap_core i_sub_swap_core (.clock(clock), .rstn(rstn), .start(start),
        .opcode(opcode), .file_addr(file_addr), .dest_sel(dest_sel),
        .access_sel(access_sel), .bank_select_register(bank_select_register),
        .extended_en(extended_en), .index_base(index_base),
        .carry_in(carry_in), .rdata(rdata), .addr(addr), .rd_en(rd_en),
        .wr_en(wr_en), .wdata(wdata), .work_reg(work_reg),
        .carry_out(carry_out), .indexed_mode(indexed_mode), .phase(phase),
        .busy(busy), .done(done));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [11:0] exp,
        input logic [11:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One instruction with random fields, checked against the model
    task automatic run(input logic [1:0] op, input logic [7:0] f);
        int n;
        logic [11:0] ea;
        logic [7:0] r;
        logic cy;
        logic idx;
        int d;
        opcode = op;
        file_addr = f;
        {dest_sel, access_sel, extended_en, carry_in} = 4'($urandom);
        bank_select_register = 4'($urandom);
        index_base = 12'($urandom);
        rdata = 8'($urandom);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        idx = extended_en && !access_sel && f <= 8'h5f;
        ea = access_sel ? {bank_select_register, f}
            : {(f < 8'h80) ? 4'h0 : 4'hf, f};
        if (idx)
            ea = index_base + {4'h0, f};
        chk("addr", ea, addr);
        chk("indexed", {11'h0, idx}, indexed_mode);
        // Start while busy must be ignored
        start = 1'b1;
        file_addr = ~f;
        n = 1;
        while (rd_en !== 1'b1 && n < 8)
        begin
            @(negedge clock);
            n++;
        end
        start = 1'b0;
        chk("held addr", ea, addr);
        chk("read cycle", 12'h2, n[11:0]);
        chk("read phase", sub_swap_pkg::PH_READ, phase);
        while (done !== 1'b1 && n < 8)
        begin
            @(negedge clock);
            n++;
        end
        chk("done cycle", 12'h4, n[11:0]);
        chk("write phase", sub_swap_pkg::PH_WRITE, phase);
        if (n >= 8)
            results;
        r = {rdata[3:0], rdata[7:4]};
        cy = carry_in;
        if (op == sub_swap_pkg::OP_SUB_BORROW)
        begin
            // f minus W minus inverted carry; carry set when no borrow
            d = int'(rdata) - int'(w_model) - (carry_in ? 0 : 1);
            r = 8'(d);
            cy = (d >= 0);
        end
        chk("wdata", r, wdata);
        chk("carry", cy, carry_out);
        chk("wr_en", dest_sel, wr_en);
        @(negedge clock);
        if (!dest_sel)
            w_model = r;
        chk("work_reg", w_model, work_reg);
        chk("idle", 12'h0, busy);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(48));
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        chk("work reset", sub_swap_pkg::W_RESET, work_reg);
        for (int i = 0; i < 80; i++)
            run(2'(1 + i % 2), i < 8 ? dirs[i] : 8'($urandom));
        for (int k = 0; k < 4; k += 3)
        begin
            opcode = 2'(k);
            start = 1'b1;
            @(negedge clock);
            start = 1'b0;
            @(negedge clock);
            chk("refused", 12'h0, busy);
        end
        results;
    end
endmodule
`default_nettype wire
